// File: rtl/afsp_params.svh
`ifndef AFSP_PARAMS_SVH
`define AFSP_PARAMS_SVH

// Frame geometry
`define AFSP_FRAME_BITS 16
`define AFSP_CTRL_BITS  5
`define AFSP_CH_BITS    3
`define AFSP_RES_BITS   12
// Channel field position inside the control word
`define AFSP_CH_LSB     0
// Offset binary to two's complement flip
`define AFSP_SIGN_FLIP  12'h800

// Timing
`define AFSP_CLK_NS     100
`define AFSP_BBM_NS     200
`define AFSP_BBM_CYC    ((`AFSP_BBM_NS + `AFSP_CLK_NS - 1) / `AFSP_CLK_NS)
`define AFSP_SCLK_HALF  4

// Host register map
`define AFSP_ADDR_CFG   4'h0
`define AFSP_ADDR_TX    4'h1
`define AFSP_ADDR_GO    4'h2
`define AFSP_ADDR_STAT  4'h3
`define AFSP_ADDR_RX    4'h4
`define AFSP_CFG_RST    1'h1
`define AFSP_GO_SEND    0
`define AFSP_GO_RECV    1

`endif

// File: rtl/afsp_pkg.sv
package afsp_pkg;

  // Device output frame sequencer
  typedef enum logic [2:0] {
    AFSP_OF_IDLE  = 3'b001,
    AFSP_OF_ARM   = 3'b010,
    AFSP_OF_SHIFT = 3'b100
  } afsp_of_state_t;

  // Host frame sequencer
  typedef enum logic [2:0] {
    AFSP_H_IDLE = 3'b001,
    AFSP_H_RUN  = 3'b010,
    AFSP_H_TAIL = 3'b100
  } afsp_h_state_t;

endpackage

// File: rtl/afsp_if.sv
`timescale 1ns/1ns
`default_nettype none

interface afsp_if;
  logic clocking_mode_select;
  logic input_frame_sync_n;
  logic din;
  logic dout;
  logic sclk_dev_o;
  logic sclk_dev_oe_n;
  logic sclk_host_o;
  logic sclk_host_oe_n;
  logic ofs_dev_o;
  logic ofs_dev_oe_n;
  logic ofs_host_o;
  logic ofs_host_oe_n;
  logic sclk;
  logic output_frame_sync_n;

  // Wire level of the two shared pins, pulled high when nobody drives
  assign sclk = !sclk_dev_oe_n  ? sclk_dev_o  :
                !sclk_host_oe_n ? sclk_host_o : 1'b1;
  assign output_frame_sync_n = !ofs_dev_oe_n  ? ofs_dev_o  :
                               !ofs_host_oe_n ? ofs_host_o : 1'b1;

  modport dev (
    input  clocking_mode_select,
    input  input_frame_sync_n,
    input  din,
    input  sclk,
    input  output_frame_sync_n,
    output dout,
    output sclk_dev_o,
    output sclk_dev_oe_n,
    output ofs_dev_o,
    output ofs_dev_oe_n
  );

  modport host (
    output clocking_mode_select,
    output input_frame_sync_n,
    output din,
    input  dout,
    input  sclk,
    input  output_frame_sync_n,
    output sclk_host_o,
    output sclk_host_oe_n,
    output ofs_host_o,
    output ofs_host_oe_n
  );
endinterface

`default_nettype wire

// File: rtl/afsp_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "afsp_params.svh"

module afsp_dev
  import afsp_pkg::*;
#(
  parameter bit          BIPOLAR = 1'b1,
  parameter int unsigned BBM_CYC = `AFSP_BBM_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  afsp_if.dev                            lnk,
  input  wire logic                      conv_clk,
  input  wire logic                      sample_valid,
  input  wire logic [`AFSP_RES_BITS-1:0] sample_raw,
  output logic      [`AFSP_CH_BITS-1:0]  channel_select,
  output logic                           mux_connect,
  output logic      [`AFSP_CTRL_BITS-1:0] ctrl_word,
  output logic                           ctrl_loaded,
  output logic                           frame_busy
);

  localparam int FB = `AFSP_FRAME_BITS;
  localparam int CB = `AFSP_CTRL_BITS;
  localparam int HB = `AFSP_CH_BITS;
  localparam int RB = `AFSP_RES_BITS;
  localparam logic [4:0] OUT_LAST = 5'(FB - 1);
  localparam logic [2:0] IN_LAST  = 3'(CB - 1);
  localparam logic [2:0] IN_DONE  = 3'(CB);
  localparam logic [7:0] BBM_LOAD = 8'(BBM_CYC);

  // Pin synchronisers: mode, in sync, out sync, sclk, din, conv clock
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
    end else begin
      sync1_q <= {lnk.clocking_mode_select, lnk.input_frame_sync_n,
                  lnk.output_frame_sync_n, lnk.sclk, lnk.din, conv_clk};
      sync2_q <= sync1_q;
    end
  end

  logic mode_s;
  logic ifs_s;
  logic ofs_s;
  logic sclk_s;
  logic din_s;
  logic cclk_s;
  assign {mode_s, ifs_s, ofs_s, sclk_s, din_s, cclk_s} = sync2_q;

  logic master;
  logic sclk_gen_q;
  logic ofs_gen_q;
  logic sclk_lvl;
  logic ofs_lvl;
  logic sclk_prev_q;
  logic ofs_prev_q;
  logic ifs_prev_q;
  logic cclk_prev_q;
  logic sclk_fall;
  logic sclk_rise;
  logic ofs_fall;
  logic ifs_fall;
  logic cclk_rise;

  assign master = ~mode_s;
  assign sclk_lvl  = master ? sclk_gen_q : sclk_s;
  assign ofs_lvl   = master ? ofs_gen_q  : ofs_s;
  assign sclk_fall = sclk_prev_q & ~sclk_lvl;
  assign sclk_rise = ~sclk_prev_q & sclk_lvl;
  assign ofs_fall  = ofs_prev_q & ~ofs_lvl;
  assign ifs_fall  = ifs_prev_q & ~ifs_s;
  assign cclk_rise = ~cclk_prev_q & cclk_s;

  // Edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b1;
      ofs_prev_q  <= 1'b1;
      ifs_prev_q  <= 1'b1;
      cclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_lvl;
      ofs_prev_q  <= ofs_lvl;
      ifs_prev_q  <= ifs_s;
      cclk_prev_q <= cclk_s;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_gen_q <= 1'b1;
    end else if (!master) begin
      sclk_gen_q <= 1'b1;
    end else if (cclk_rise) begin
      sclk_gen_q <= ~sclk_gen_q;
    end
  end

  // Conversion result capture
  logic [RB-1:0] res_q;
  logic [HB-1:0] res_ch_q;
  logic          pend_q;
  logic          load;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_q    <= '0;
      res_ch_q <= '0;
    end else if (sample_valid) begin
      res_q    <= BIPOLAR ? (sample_raw ^ `AFSP_SIGN_FLIP) : sample_raw;
      res_ch_q <= channel_select;
    end
  end

  // Pending result, new sample wins over a frame load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (sample_valid) begin
      pend_q <= 1'b1;
    end else if (load) begin
      pend_q <= 1'b0;
    end
  end

  // Output frame sequencer
  afsp_of_state_t of_state_q;
  logic [4:0]     ocnt_q;
  logic [FB-1:0]  osh_q;
  assign load = ((of_state_q == AFSP_OF_IDLE) && !master && ofs_fall) ||
                ((of_state_q == AFSP_OF_ARM) && sclk_rise);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      of_state_q <= AFSP_OF_IDLE;
      ofs_gen_q  <= 1'b1;
      ocnt_q     <= 5'h00;
      osh_q      <= '0;
    end else begin
      case (of_state_q)
        AFSP_OF_IDLE: begin
          ofs_gen_q <= 1'b1;
          if (master && pend_q) begin
            of_state_q <= AFSP_OF_ARM;
          end else if (load) begin
            of_state_q <= AFSP_OF_SHIFT;
          end
        end
        AFSP_OF_ARM: begin
          if (!master) begin
            of_state_q <= AFSP_OF_IDLE;
          end else if (load) begin
            ofs_gen_q  <= 1'b0;
            of_state_q <= AFSP_OF_SHIFT;
          end
        end
        AFSP_OF_SHIFT: begin
          if (!master && ofs_s) begin
            of_state_q <= AFSP_OF_IDLE;
          end else if (sclk_fall) begin
            // next bit after each sampled fall
            osh_q  <= {osh_q[FB-2:0], 1'b0};
            ocnt_q <= ocnt_q + 5'h01;
            if (ocnt_q == OUT_LAST) begin
              ofs_gen_q  <= 1'b1;
              of_state_q <= AFSP_OF_IDLE;
            end
          end
        end
        default: begin
          of_state_q <= AFSP_OF_IDLE;
          ofs_gen_q  <= 1'b1;
        end
      endcase
      if (load) begin
        osh_q  <= {1'b0, res_ch_q, res_q};
        ocnt_q <= 5'h00;
      end
    end
  end

  // Control word input
  logic [2:0]    icnt_q;
  logic [CB-2:0] ish_q;
  logic [CB-1:0] ctrl_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      icnt_q      <= IN_DONE;
      ish_q       <= '0;
      ctrl_q      <= '0;
      ctrl_loaded <= 1'b0;
    end else begin
      ctrl_loaded <= 1'b0;
      if (ifs_fall) begin
        icnt_q <= 3'h0;
      end else if (sclk_fall && !ifs_s && icnt_q != IN_DONE) begin
        ish_q  <= {ish_q[CB-3:0], din_s};
        icnt_q <= icnt_q + 3'h1;
        if (icnt_q == IN_LAST) begin
          ctrl_q      <= {ish_q, din_s};
          ctrl_loaded <= 1'b1;
        end
      end
    end
  end

  // Multiplexer steering with a dead gap on every change
  logic [HB-1:0] ch_want;
  logic [7:0]    bbm_q;
  assign ch_want = ctrl_q[`AFSP_CH_LSB +: HB];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_select <= '0;
      mux_connect    <= 1'b1;
      bbm_q          <= 8'h00;
    end else if (mux_connect) begin
      if (ch_want != channel_select) begin
        mux_connect <= 1'b0;
        bbm_q       <= BBM_LOAD;
      end
    end else if (bbm_q != 8'h00) begin
      bbm_q <= bbm_q - 8'h01;
    end else if (ch_want != channel_select) begin
      channel_select <= ch_want;
    end else begin
      mux_connect <= 1'b1;
    end
  end

  assign ctrl_word  = ctrl_q;
  assign frame_busy = (of_state_q != AFSP_OF_IDLE);

  // Pin drive, enables low while driving
  assign lnk.dout          = osh_q[FB-1];
  assign lnk.sclk_dev_o    = sclk_gen_q;
  assign lnk.sclk_dev_oe_n = ~master;
  assign lnk.ofs_dev_o     = ofs_gen_q;
  assign lnk.ofs_dev_oe_n  = ~master;

endmodule

`default_nettype wire

// File: rtl/afsp_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "afsp_params.svh"

module afsp_host
  import afsp_pkg::*;
#(
  parameter int unsigned SCLK_HALF = `AFSP_SCLK_HALF
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  afsp_if.host             lnk,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);

  localparam int FB = `AFSP_FRAME_BITS;
  localparam int CB = `AFSP_CTRL_BITS;
  localparam logic [4:0] LAST_FULL = 5'(FB - 1);
  localparam logic [4:0] LAST_CTRL = 5'(CB - 1);
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  // Pin synchronisers: sclk, out sync, dout
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {lnk.sclk, lnk.output_frame_sync_n, lnk.dout};
      sync2_q <= sync1_q;
    end
  end

  logic cfg_q;
  logic [CB-1:0] tx_q;
  logic          go;
  logic          rx_set;
  logic          rx_valid_q;
  logic [FB-1:0] rx_q;
  afsp_h_state_t st_q;

  // Configuration and control word registers
  assign go = reg_wr && (reg_addr == `AFSP_ADDR_GO) && (st_q == AFSP_H_IDLE);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= `AFSP_CFG_RST;
      tx_q  <= '0;
    end else if (reg_wr && st_q == AFSP_H_IDLE) begin
      if (reg_addr == `AFSP_ADDR_CFG) begin
        cfg_q <= reg_wdata[0];
      end
      if (reg_addr == `AFSP_ADDR_TX) begin
        tx_q <= reg_wdata[CB-1:0];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AFSP_ADDR_CFG:  reg_rdata <= {15'h0000, cfg_q};
        `AFSP_ADDR_TX:   reg_rdata <= {11'h000, tx_q};
        `AFSP_ADDR_STAT: reg_rdata <= {14'h0000, rx_valid_q,
                                       st_q != AFSP_H_IDLE};
        `AFSP_ADDR_RX:   reg_rdata <= rx_q;
        default:         reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Edge finding on whichever clock runs the link
  logic hclk;
  logic sclk_gen_q;
  logic ofs_gen_q;
  logic sclk_lvl;
  logic ofs_lvl;
  logic sclk_prev_q;
  logic ofs_prev_q;
  logic sclk_fall;
  logic ofs_fall;
  logic sclk_rise;
  assign hclk      = cfg_q;
  assign sclk_lvl  = hclk ? sclk_gen_q : sync2_q[2];
  assign ofs_lvl   = hclk ? ofs_gen_q  : sync2_q[1];
  assign sclk_fall = sclk_prev_q & ~sclk_lvl;
  assign ofs_fall  = ofs_prev_q & ~ofs_lvl;
  assign sclk_rise = ~sclk_prev_q & sclk_lvl;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b1;
      ofs_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_lvl;
      ofs_prev_q  <= ofs_lvl;
    end
  end

  // Serial clock divider, runs only inside a host-clocked frame
  logic [7:0] div_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q      <= 8'h00;
      sclk_gen_q <= 1'b1;
    end else if (!hclk || st_q == AFSP_H_IDLE) begin
      div_q      <= 8'h00;
      sclk_gen_q <= 1'b1;
    end else if (div_q == HALF_LAST) begin
      div_q      <= 8'h00;
      sclk_gen_q <= (st_q == AFSP_H_TAIL) ? 1'b1 : ~sclk_gen_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Transmit sequencer and frame syncs
  logic [4:0]    tcnt_q;
  logic [CB-1:0] tsh_q;
  logic          ifs_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q      <= AFSP_H_IDLE;
      tcnt_q    <= 5'h00;
      tsh_q     <= '0;
      ifs_q     <= 1'b1;
      ofs_gen_q <= 1'b1;
    end else begin
      case (st_q)
        AFSP_H_IDLE: begin
          if (go && (hclk || reg_wdata[`AFSP_GO_SEND])) begin
            ifs_q     <= ~(hclk & reg_wdata[`AFSP_GO_SEND]);
            ofs_gen_q <= ~(hclk & reg_wdata[`AFSP_GO_RECV]);
            tsh_q     <= tx_q;
            tcnt_q    <= 5'h00;
            // Device clock: wait for a high phase first
            st_q      <= hclk ? AFSP_H_RUN : AFSP_H_TAIL;
          end
        end
        AFSP_H_RUN: begin
          if (sclk_fall) begin
            tsh_q  <= {tsh_q[CB-2:0], 1'b0};
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == (hclk ? LAST_FULL : LAST_CTRL)) begin
              ifs_q     <= 1'b1;
              ofs_gen_q <= 1'b1;
              st_q      <= hclk ? AFSP_H_TAIL : AFSP_H_IDLE;
            end
          end
        end
        AFSP_H_TAIL: begin
          if (hclk) begin
            if (sclk_gen_q) begin
              st_q <= AFSP_H_IDLE;
            end
          end else if (sclk_rise) begin
            // sync falls well before a fall
            ifs_q <= 1'b0;
            st_q  <= AFSP_H_RUN;
          end
        end
        default: begin
          st_q <= AFSP_H_IDLE;
        end
      endcase
    end
  end

  // Receive: sample dout at each fall after the output sync falls
  logic          ract_q;
  logic [4:0]    rcnt_q;
  logic [FB-1:0] rsh_q;
  assign rx_set = ract_q && sclk_fall && (rcnt_q == LAST_FULL);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ract_q <= 1'b0;
      rcnt_q <= 5'h00;
      rsh_q  <= '0;
      rx_q   <= '0;
    end else if (ofs_fall) begin
      ract_q <= 1'b1;
      rcnt_q <= 5'h00;
    end else if (ract_q && sclk_fall) begin
      rsh_q  <= {rsh_q[FB-2:0], sync2_q[0]};
      rcnt_q <= rcnt_q + 5'h01;
      if (rcnt_q == LAST_FULL) begin
        rx_q   <= {rsh_q[FB-2:0], sync2_q[0]};
        ract_q <= 1'b0;
      end
    end
  end

  // Frame ready flag, a new frame wins over a read of RX
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_valid_q <= 1'b0;
    end else if (rx_set) begin
      rx_valid_q <= 1'b1;
    end else if (reg_rd && reg_addr == `AFSP_ADDR_RX) begin
      rx_valid_q <= 1'b0;
    end
  end

  assign lnk.clocking_mode_select = cfg_q;
  assign lnk.input_frame_sync_n   = ifs_q;
  assign lnk.din                  = tsh_q[CB-1];
  assign lnk.sclk_host_o          = sclk_gen_q;
  assign lnk.sclk_host_oe_n       = ~hclk;
  assign lnk.ofs_host_o           = ofs_gen_q;
  assign lnk.ofs_host_oe_n        = ~hclk;

endmodule

`default_nettype wire

// File: verif/afsp_props.sv
`timescale 1ns/1ns
`default_nettype none

module afsp_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clocking_mode_select,
  input wire logic input_frame_sync_n,
  input wire logic dout,
  input wire logic sclk_dev_oe_n,
  input wire logic sclk_host_oe_n,
  input wire logic ofs_dev_oe_n,
  input wire logic ofs_host_oe_n,
  input wire logic sclk,
  input wire logic output_frame_sync_n
);
  logic       sclk_q;
  logic       ofs_q;
  logic       ifs_q;
  logic [4:0] ocnt_q;
  logic [4:0] icnt_q;
  logic       fall;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Serial clock fall seen this cycle
  assign fall = sclk_q && !sclk;

  // Previous wire levels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b1;
      ofs_q  <= 1'b1;
      ifs_q  <= 1'b1;
    end else begin
      sclk_q <= sclk;
      ofs_q  <= output_frame_sync_n;
      ifs_q  <= input_frame_sync_n;
    end
  end

  // Falls counted inside each frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ocnt_q <= 5'h0;
      icnt_q <= 5'h0;
    end else begin
      if (ofs_q && !output_frame_sync_n) ocnt_q <= 5'h0;
      else if (fall && !ofs_q && ocnt_q != 5'h1F) ocnt_q <= ocnt_q + 5'h1;
      if (ifs_q && !input_frame_sync_n) icnt_q <= 5'h0;
      else if (fall && !ifs_q && icnt_q != 5'h1F) icnt_q <= icnt_q + 5'h1;
    end
  end

  AST_SELF_DRIVES: assert property (
    (!clocking_mode_select) [*6] |-> !sclk_dev_oe_n && !ofs_dev_oe_n)
    else $error("device not driving in self clocking");
  AST_EXT_RELEASES: assert property (
    clocking_mode_select [*6] |-> sclk_dev_oe_n && ofs_dev_oe_n)
    else $error("device drives in external clocking");
  AST_NO_CLASH: assert property (
    !(!sclk_dev_oe_n && !sclk_host_oe_n) && !(!ofs_dev_oe_n && !ofs_host_oe_n))
    else $error("two drivers on a shared pin");
  AST_LEAD_ZERO: assert property (
    (ocnt_q == 5'h0 && fall && !ofs_q) |-> !dout)
    else $error("first output bit not zero");
  AST_SIXTEEN: assert property (
    $rose(output_frame_sync_n) |=> ocnt_q == 5'd16)
    else $error("output frame not sixteen falls");
  AST_FIVE_IN: assert property (
    $rose(input_frame_sync_n) |=> icnt_q >= 5'd5)
    else $error("control frame under five falls");
  AST_BIT_AT_FALL: assert property (
    (fall && !ofs_q) |-> $stable(dout))
    else $error("output bit moves at a fall");
  AST_IDLE_HIGH: assert property (
    (clocking_mode_select && input_frame_sync_n && output_frame_sync_n) [*8]
    |-> sclk)
    else $error("serial clock not idle high");
  AST_HALF_LOW: assert property (
    (clocking_mode_select && $fell(sclk)) |-> (!sclk) [*4] ##1 sclk)
    else $error("serial clock low phase wrong");

  // Main traffic kinds
  COV_EXT_FRAME: cover property (clocking_mode_select && $fell(output_frame_sync_n));
  COV_SELF_FRAME: cover property (!clocking_mode_select && $fell(output_frame_sync_n));
  COV_CTRL_FRAME: cover property (!clocking_mode_select && $rose(input_frame_sync_n));
endmodule

`default_nettype wire

// File: verif/test_adc_framed_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "afsp_params.svh"

module test_adc_framed_serial_port
  import afsp_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        conv_clk = 1'b0;
  logic        sample_valid = 1'b0;
  logic [11:0] sample_raw = 12'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [2:0]  channel_select;
  logic        mux_connect;
  logic [4:0]  ctrl_word;
  logic        ctrl_loaded;
  logic        frame_busy;
  logic [2:0]  ch_prev;
  logic        mux_prev;
  logic [15:0] rv;
  logic [15:0] tx;
  logic [15:0] exp_q[$];
  integer      num_errors = 0;
  integer      total_checks = 0;
  integer      seed = 4;
  integer      cyc = 0;
  integer      ch_m = 0;
  integer      ctl_m = 0;
  integer      n_ld = 0;
  integer      n_tx = 0;
  integer      i;
  integer      n;

  afsp_if lnk ();

  afsp_dev #(.BIPOLAR(1'b1), .BBM_CYC(2)) i_afsp_dev (
    .clk(clk), .sys_rst(sys_rst), .lnk(lnk), .conv_clk(conv_clk),
    .sample_valid(sample_valid), .sample_raw(sample_raw),
    .channel_select(channel_select), .mux_connect(mux_connect),
    .ctrl_word(ctrl_word), .ctrl_loaded(ctrl_loaded),
    .frame_busy(frame_busy));

  afsp_host #(.SCLK_HALF(4)) i_afsp_host (
    .clk(clk), .sys_rst(sys_rst), .lnk(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  afsp_props i_afsp_props (
    .clk(clk), .sys_rst(sys_rst),
    .clocking_mode_select(lnk.clocking_mode_select),
    .input_frame_sync_n(lnk.input_frame_sync_n), .dout(lnk.dout),
    .sclk_dev_oe_n(lnk.sclk_dev_oe_n), .sclk_host_oe_n(lnk.sclk_host_oe_n),
    .ofs_dev_oe_n(lnk.ofs_dev_oe_n), .ofs_host_oe_n(lnk.ofs_host_oe_n),
    .sclk(lnk.sclk), .output_frame_sync_n(lnk.output_frame_sync_n));

  // Clocks: system 100 ns, conversion clock period of 16 cycles
  always #50 clk = ~clk;
  always #800 conv_clk = ~conv_clk;

  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task results();
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task rst();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // One conversion result, model frame queued
  task sample();
    logic [11:0] r;
    r = 12'($random(seed));
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_raw   <= r;
    @(posedge clk);
    sample_valid <= 1'b0;
    exp_q.push_back({1'b0, 3'(ch_m), r ^ `AFSP_SIGN_FLIP});
  endtask

  // Poll a status bit under a bound
  task wait_stat(input integer b, input logic lvl);
    n = 0;
    repeat (4) @(posedge clk);
    rd(`AFSP_ADDR_STAT, rv);
    while (rv[b] !== lvl && n < 3000) begin
      rd(`AFSP_ADDR_STAT, rv);
      n++;
    end
    if (n >= 3000) cmp("status wait", 16'(lvl), 16'(rv[b]));
  endtask

  task check_rx();
    rd(`AFSP_ADDR_STAT, rv);
    cmp("status full", 16'h0002, rv);
    cmp("frame idle", 16'h0000, {15'h0, frame_busy});
    rd(`AFSP_ADDR_RX, rv);
    cmp("frame", exp_q.pop_front(), rv);
    rd(`AFSP_ADDR_STAT, rv);
    cmp("status empty", 16'h0000, rv);
  endtask

  task send(input logic [15:0] go);
    tx = 16'($random(seed)) & 16'h001F;
    wr(`AFSP_ADDR_TX, tx);
    wr(`AFSP_ADDR_GO, go);
    wait_stat(0, 1'b0);
    // Only a send frame changes the control word
    if (go[0]) begin
      ch_m  = tx[2:0];
      ctl_m = tx;
      n_tx++;
    end
    repeat (8) @(posedge clk);
    cmp("control", 16'(ctl_m), {11'h0, ctrl_word});
    cmp("channel", 16'(ch_m), {13'h0, channel_select});
    cmp("loads", 16'(n_tx), 16'(n_ld));
  endtask

  // Count control word loads
  always @(posedge clk) begin
    if (ctrl_loaded === 1'b1) n_ld++;
  end

  // Channel may only move while the multiplexer is open
  always @(posedge clk) begin
    if (!sys_rst && channel_select !== ch_prev)
      cmp("mux open", 16'h0, {15'h0, mux_prev | mux_connect});
    ch_prev  <= channel_select;
    mux_prev <= mux_connect;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    rst();
    rd(4'h5, rv);
    cmp("unmapped", 16'h0000, rv);
    rd(`AFSP_ADDR_CFG, rv);
    cmp("cfg reset", 16'h0001, rv);
    // Host clocked: result out and control in, one receive only
    for (i = 0; i < 6; i++) begin
      sample();
      send((i == 3) ? 16'h0002 : 16'h0003);
      check_rx();
    end
    rst();
    ch_m = 0;
    ctl_m = 0;
    exp_q.delete();
    cmp("control reset", 16'h0000, {11'h0, ctrl_word});
    rd(`AFSP_ADDR_CFG, rv);
    cmp("cfg again", 16'h0001, rv);
    // Device clocked from the conversion clock
    wr(`AFSP_ADDR_CFG, 16'h0000);
    repeat (16) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      sample();
      repeat (2) @(posedge clk);
      cmp("armed", 16'h0001, {15'h0, frame_busy});
      wait_stat(1, 1'b1);
      check_rx();
      send(16'h0001);
    end
    results();
  end
endmodule

`default_nettype wire
